// ### core/adc_conversion_sequencer.sv
// Conversion sequencer: registers, strobe, power-down and status pin.
// Operation
// - Synced serial clock start: 36 serial clocks.
// - Unsynced start may take one clock more.
// - Auto channel select is the default.
// - Auto sequencing starts on channel 0.
// - Clearing auto enable stops sequencing next cycle.
// - Strobe falling edge ends sampling, starts hold.
// - Start strobe ignores frame select.
// - Conversion takes 18 conversion clocks.
// - Auto trigger waits 3 clocks acquiring.
// - Manual EOC active during whole conversion.
// - Auto trigger EOC active 3 clocks.
// - Bit 6 picks EOC or interrupt.
// - Bit 7 sets status pin polarity.
// - Power-down keeps config, aborts conversion.
// - Bit 2 low: deep sleep, oscillator off.
// - Bit 3 low: nap at once, 3-clock wake.
// - Bit 4 low enables auto nap after conversions.
// - Strobe or listed commands leave auto nap.
// - Wake command sets bits 2,3, wakes.
// - Serial clock halved for conversion clock.
// - Commands and config writes apply on write.
// - Commands 0 and 1 pick channel.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
module adc_conversion_sequencer (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // AXI4-Lite write address and data.
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read.
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Converter pins.
  input wire logic sclk,
  input wire logic conversion_start_n,
  output logic status_pin,
  // Analog core controls.
  output adc_seq_pkg::ana_s ana
);
  adc_seq_pkg::seq_s q;
  adc_seq_pkg::seq_s nxt;
  logic conversion_clock_tick;

  // Decodes a mapped register offset; used on both bus directions.
  function automatic logic reg_hit(input logic [3:0] a);
    reg_hit = (a == adc_seq_pkg::OFS_CMD) || (a == adc_seq_pkg::OFS_CFG)
      || (a == adc_seq_pkg::OFS_STAT);
  endfunction

  // ----------------------------------------------------------------
  // Conversion clock source
  // ----------------------------------------------------------------
  // Oscillator runs only when selected and not in deep sleep.
  conversion_clock_gen u_conversion_clock (
    .clk(clk),
    .srst(srst),
    .sclk(sclk),
    .ext_sel(!q.cfg[adc_seq_pkg::B_CLK_SRC]),
    .osc_en(q.cfg[adc_seq_pkg::B_CLK_SRC] && q.ana.osc_on),
    .conversion_clock_tick(conversion_clock_tick)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus slave, command decode, sequencer and status pin.
  always_comb begin
    logic fall;
    logic wr_go;
    logic anap_wake;
    logic pd;
    logic eoc_act;
    logic act;
    logic [3:0] nib;
    adc_seq_pkg::stat_s stat;
    nxt = q;
    fall = 1'b0;
    wr_go = 1'b0;
    anap_wake = 1'b0;
    pd = 1'b0;
    eoc_act = 1'b0;
    act = 1'b0;
    nib = q.wdata[15:12];
    stat = '0;
    nxt.eoc = 1'b0;
    nxt.start_s1 = conversion_start_n;
    nxt.start_s2 = q.start_s1;
    nxt.start_s3 = q.start_s2;
    fall = q.start_s3 && !q.start_s2;

    // Write address and data are taken in either order.
    if (awvalid && q.awready) begin
      nxt.aw_got = 1'b1;
      nxt.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      nxt.w_got = 1'b1;
      nxt.wdata = wdata[15:0];
      nxt.wok = &wstrb[1:0];
    end
    if (bready && q.bvalid) begin
      nxt.bvalid = 1'b0;
    end
    wr_go = q.aw_got && q.w_got && !q.bvalid;

    if (wr_go) begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = reg_hit(q.awaddr) ? adc_seq_pkg::RESP_OKAY :
        adc_seq_pkg::RESP_SLVERR;
      if (q.wok && q.awaddr == adc_seq_pkg::OFS_CFG) begin
        nxt.cfg = q.wdata[11:0];
      end
      if (q.wok && q.awaddr == adc_seq_pkg::OFS_CMD) begin
        if (!nib[3]) begin
          anap_wake = 1'b1;
          if (!q.cfg[adc_seq_pkg::B_AUTO_CH] && nib[2:1] == 2'h0) begin
            nxt.ana.chan = nib[0];
          end
        end
        case (nib)
          adc_seq_pkg::CMD_WAKE: begin
            nxt.cfg[adc_seq_pkg::B_DEEP] = 1'b1;
            nxt.cfg[adc_seq_pkg::B_NAP] = 1'b1;
            anap_wake = 1'b1;
          end
          adc_seq_pkg::CMD_RD_DATA: nxt.int_act = 1'b0;
          adc_seq_pkg::CMD_WR_CFG: nxt.cfg = q.wdata[11:0];
          adc_seq_pkg::CMD_DEFAULT: begin
            nxt.cfg = adc_seq_pkg::CFG_RESET;
            anap_wake = 1'b1;
          end
          default: begin
            nxt.cfg = nxt.cfg;
          end
        endcase
      end
    end

    // Read channel answers one cycle after the address is taken.
    if (rready && q.rvalid) begin
      nxt.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      stat.st = q.st;
      stat.chan = q.ana.chan;
      stat.hold = q.ana.hold;
      stat.int_act = q.int_act;
      stat.anap = q.anap;
      stat.deep = q.deep;
      stat.status_pin = q.status_pin;
      nxt.rvalid = 1'b1;
      nxt.rresp = reg_hit(araddr) ? adc_seq_pkg::RESP_OKAY :
        adc_seq_pkg::RESP_SLVERR;
      if (araddr == adc_seq_pkg::OFS_CFG) begin
        nxt.rdata = {20'h00000, q.cfg};
      end else if (araddr == adc_seq_pkg::OFS_STAT) begin
        nxt.rdata = {23'h000000, stat};
      end else begin
        nxt.rdata = 32'h00000000;
      end
    end

    if (nxt.cfg[adc_seq_pkg::B_AUTO_CH] && !q.cfg[adc_seq_pkg::B_AUTO_CH])
    begin
      nxt.ana.chan = 1'b0;
    end
    if (nxt.cfg[adc_seq_pkg::B_AUTONAP]) begin
      anap_wake = 1'b1;
    end
    if (fall) begin
      anap_wake = 1'b1;
    end
    pd = !nxt.cfg[adc_seq_pkg::B_DEEP] || !nxt.cfg[adc_seq_pkg::B_NAP];

    case (q.st)
      adc_seq_pkg::ST_SAMPLE: begin
        if (!q.cfg[adc_seq_pkg::B_TRIG]) begin
          nxt.st = adc_seq_pkg::ST_ACQ;
          nxt.cnt = 8'h00;
        end else if (fall) begin
          nxt.st = adc_seq_pkg::ST_CONV;
          nxt.cnt = 8'h00;
          nxt.ana.hold = 1'b1;
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (conversion_clock_tick && q.cnt == adc_seq_pkg::CONV_CCLKS - 8'h01) begin
          nxt.ana.hold = 1'b0;
          nxt.eoc = 1'b1;
          nxt.int_act = 1'b1;
          if (q.cfg[adc_seq_pkg::B_AUTO_CH]) begin
            nxt.ana.chan = ~q.ana.chan;
          end
          if (!q.cfg[adc_seq_pkg::B_AUTONAP]) begin
            nxt.st = adc_seq_pkg::ST_PDOWN;
            nxt.anap = 1'b1;
            nxt.deep = 1'b0;
          end else if (!q.cfg[adc_seq_pkg::B_TRIG]) begin
            nxt.st = adc_seq_pkg::ST_ACQ;
            nxt.cnt = 8'h00;
          end else begin
            nxt.st = adc_seq_pkg::ST_SAMPLE;
          end
        end else if (conversion_clock_tick) begin
          nxt.cnt = q.cnt + 8'h01;
        end
      end
      adc_seq_pkg::ST_ACQ: begin
        if (q.cfg[adc_seq_pkg::B_TRIG]) begin
          nxt.st = adc_seq_pkg::ST_SAMPLE;
        end else if (conversion_clock_tick && q.cnt == adc_seq_pkg::ACQ_CCLKS - 8'h01)
        begin
          nxt.st = adc_seq_pkg::ST_CONV;
          nxt.cnt = 8'h00;
          nxt.ana.hold = 1'b1;
        end else if (conversion_clock_tick) begin
          nxt.cnt = q.cnt + 8'h01;
        end
      end
      adc_seq_pkg::ST_PDOWN: begin
        if (!pd && (!q.anap || anap_wake)) begin
          nxt.st = adc_seq_pkg::ST_WAKE;
          nxt.cnt = 8'h00;
          nxt.anap = 1'b0;
        end
      end
      adc_seq_pkg::ST_WAKE: begin
        if (q.deep) begin
          if (q.cnt == adc_seq_pkg::DEEP_WAKE_LAST) begin
            nxt.st = adc_seq_pkg::ST_SAMPLE;
            nxt.deep = 1'b0;
          end else begin
            nxt.cnt = q.cnt + 8'h01;
          end
        end else if (conversion_clock_tick) begin
          if (q.cnt == adc_seq_pkg::NAP_WAKE_CCLKS - 8'h01) begin
            nxt.st = adc_seq_pkg::ST_SAMPLE;
          end else begin
            nxt.cnt = q.cnt + 8'h01;
          end
        end
      end
      default: begin
        nxt.st = adc_seq_pkg::ST_SAMPLE;
      end
    endcase

    if (pd && q.st != adc_seq_pkg::ST_PDOWN) begin
      nxt.st = adc_seq_pkg::ST_PDOWN;
      nxt.ana.hold = 1'b0;
      nxt.anap = 1'b0;
    end
    if (pd) begin
      nxt.deep = !nxt.cfg[adc_seq_pkg::B_DEEP] || (nxt.deep && !nxt.anap);
    end

    // Bus readiness follows the pending transfers.
    nxt.awready = !nxt.aw_got && !nxt.bvalid;
    nxt.wready = !nxt.w_got && !nxt.bvalid;
    nxt.arready = !nxt.rvalid;
    nxt.ana.bias_on = nxt.st != adc_seq_pkg::ST_PDOWN;
    nxt.ana.osc_on = !(nxt.st == adc_seq_pkg::ST_PDOWN && nxt.deep);

    eoc_act = nxt.cfg[adc_seq_pkg::B_TRIG] ?
      (nxt.st == adc_seq_pkg::ST_CONV) : (nxt.st == adc_seq_pkg::ST_ACQ);
    act = nxt.cfg[adc_seq_pkg::B_FUNC] ? eoc_act : nxt.int_act;
    nxt.status_pin = nxt.cfg[adc_seq_pkg::B_POL] ? !act : act;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // auto channel default.
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.st <= adc_seq_pkg::ST_SAMPLE;
      q.cfg <= adc_seq_pkg::CFG_RESET;
      q.status_pin <= 1'b1;
      q.start_s1 <= 1'b1;
      q.start_s2 <= 1'b1;
      q.start_s3 <= 1'b1;
      q.ana <= adc_seq_pkg::ANA_RST;
    end else begin
      q <= nxt;
    end
  end

  // Outputs straight from the state register.
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
  assign status_pin = q.status_pin;
  assign ana = q.ana;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Tick counts during hold and acquisition, for the checks only.
  logic [7:0] hc_conv;
  logic [7:0] hc_acq;
  always_ff @(posedge clk) begin
    if (srst || !q.ana.hold) begin
      hc_conv <= 8'h00;
    end else if (conversion_clock_tick) begin
      hc_conv <= hc_conv + 8'h01;
    end
    if (srst || q.st != adc_seq_pkg::ST_ACQ) begin
      hc_acq <= 8'h00;
    end else if (conversion_clock_tick) begin
      hc_acq <= hc_acq + 8'h01;
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_hold_on_fall: assert property (
    q.start_s3 && !q.start_s2 && q.st == adc_seq_pkg::ST_SAMPLE &&
    q.cfg[adc_seq_pkg::B_TRIG] && q.cfg[adc_seq_pkg::B_NAP] &&
    q.cfg[adc_seq_pkg::B_DEEP] && !(q.aw_got && q.w_got) |=> q.ana.hold)
    else $error("Hold did not follow the strobe fall.");
  a_conv_length: assert property (
    q.eoc |-> hc_conv == adc_seq_pkg::CONV_CCLKS && !q.ana.hold)
    else $error("Conversion did not last 18 clocks.");
  a_acq_length: assert property (
    $rose(q.ana.hold) && $past(q.st) == adc_seq_pkg::ST_ACQ |->
    hc_acq == adc_seq_pkg::ACQ_CCLKS)
    else $error("Auto acquisition did not last 3 clocks.");
  a_eoc_level: assert property (
    q.cfg[7:6] == 2'h3 && q.cfg[adc_seq_pkg::B_TRIG] |->
    q.status_pin == (q.st != adc_seq_pkg::ST_CONV))
    else $error("Status pin does not track the conversion.");
  a_int_set: assert property (
    q.eoc ##1 q.cfg[7:6] == 2'h2 && !q.aw_got |-> !q.status_pin)
    else $error("Interrupt not raised at end of conversion.");
  a_nap_abort: assert property (
    $fell(q.cfg[adc_seq_pkg::B_NAP]) |->
    q.st == adc_seq_pkg::ST_PDOWN && !q.ana.hold)
    else $error("Nap did not stop the converter at once.");
  a_deep_osc: assert property (
    $fell(q.cfg[adc_seq_pkg::B_DEEP]) |->
    q.st == adc_seq_pkg::ST_PDOWN && !q.ana.osc_on && !q.ana.bias_on)
    else $error("Deep sleep left the oscillator running.");
  a_wake_cmd: assert property (
    q.aw_got && q.w_got && !q.bvalid && q.wok &&
    q.awaddr == adc_seq_pkg::OFS_CMD &&
    q.wdata[15:12] == adc_seq_pkg::CMD_WAKE |=>
    q.cfg[3:2] == 2'h3 && q.cfg[4] == $past(q.cfg[4]))
    else $error("Wake command set the wrong config bits.");
  a_auto_first: assert property (
    $rose(q.cfg[adc_seq_pkg::B_AUTO_CH]) |-> !q.ana.chan)
    else $error("Auto sequencing did not restart on channel 0.");

  c_manual_conv: cover property (
    q.eoc && q.cfg[adc_seq_pkg::B_TRIG]);
  c_auto_conv: cover property (
    q.eoc && !q.cfg[adc_seq_pkg::B_TRIG] ##[160:200] q.eoc);
  c_auto_nap: cover property (
    q.anap ##[1:200] q.st == adc_seq_pkg::ST_WAKE);
endmodule
`default_nettype wire

// ### core/conversion_clock_gen.sv
// Conversion clock tick source: internal oscillator or serial clock / 2.
`default_nettype none
module conversion_clock_gen (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Serial clock pin and source control.
  input wire logic sclk,
  input wire logic ext_sel,
  input wire logic osc_en,
  // One-cycle tick per conversion clock.
  output logic conversion_clock_tick
);
  adc_seq_pkg::conversion_clock_s q;
  adc_seq_pkg::conversion_clock_s nxt;

  // ----------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------
  // The pin passes three flops; the edge test reads only the later two.
  always_comb begin
    nxt = q;
    nxt.s1 = sclk;
    nxt.s2 = q.s1;
    nxt.s3 = q.s2;
    nxt.tick = 1'b0;
    if (ext_sel) begin
      nxt.osc = 8'h00;
      if (q.s2 && !q.s3) begin
        nxt.div = ~q.div;
        nxt.tick = q.div;
      end
    end else if (osc_en) begin
      if (q.osc == adc_seq_pkg::OSC_LAST) begin
        nxt.osc = 8'h00;
        nxt.tick = 1'b1;
      end else begin
        nxt.osc = q.osc + 8'h01;
      end
    end else begin
      nxt.osc = 8'h00;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= adc_seq_pkg::CONVERSION_CLOCK_RST;
    end else begin
      q <= nxt;
    end
  end

  assign conversion_clock_tick = q.tick;
endmodule
`default_nettype wire

// ### pkg/adc_seq_pkg.sv
// Shared constants, state types and layouts for the conversion sequencer.
`default_nettype none
package adc_seq_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Config word fields and reset value.
  localparam logic [11:0] CFG_RESET = 12'hfff;
  localparam int B_AUTO_CH = 11;
  localparam int B_CLK_SRC = 10;
  localparam int B_TRIG = 9;
  localparam int B_POL = 7;
  localparam int B_FUNC = 6;
  localparam int B_AUTONAP = 4;
  localparam int B_NAP = 3;
  localparam int B_DEEP = 2;

  // Command nibbles.
  localparam logic [3:0] CMD_WAKE = 4'hb;
  localparam logic [3:0] CMD_RD_DATA = 4'hd;
  localparam logic [3:0] CMD_WR_CFG = 4'he;
  localparam logic [3:0] CMD_DEFAULT = 4'hf;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 80;
  localparam int DEEP_WAKE_NS = 1000;
  localparam logic [7:0] OSC_LAST =
    8'(OSC_PERIOD_NS / CLK_PERIOD_NS - 1);
  localparam logic [7:0] DEEP_WAKE_LAST =
    8'((DEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
  localparam logic [7:0] CONV_CCLKS = 8'h12;
  localparam logic [7:0] ACQ_CCLKS = 8'h03;
  localparam logic [7:0] NAP_WAKE_CCLKS = 8'h03;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0,
    ST_CONV = 3'h1,
    ST_ACQ = 3'h3,
    ST_PDOWN = 3'h2,
    ST_WAKE = 3'h6
  } seq_e;

  // Controls toward the analog core.
  typedef struct packed {
    logic hold;
    logic chan;
    logic bias_on;
    logic osc_on;
  } ana_s;

  // Status register layout, low bits of the read word.
  typedef struct packed {
    logic [2:0] st;
    logic chan;
    logic hold;
    logic int_act;
    logic anap;
    logic deep;
    logic status_pin;
  } stat_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic div;
    logic [7:0] osc;
    logic tick;
  } conversion_clock_s;

  typedef struct packed {
    seq_e st;
    logic [7:0] cnt;
    logic [11:0] cfg;
    logic int_act;
    logic anap;
    logic deep;
    logic eoc;
    logic status_pin;
    logic start_s1;
    logic start_s2;
    logic start_s3;
    ana_s ana;
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic w_got;
    logic wok;
    logic bvalid;
    logic rvalid;
    logic [3:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } seq_s;

  localparam conversion_clock_s CONVERSION_CLOCK_RST = '0;
  localparam ana_s ANA_RST = '{hold: 1'b0, chan: 1'b0, bias_on: 1'b1,
                               osc_on: 1'b1};
endpackage
`default_nettype wire

// ### tb/adc_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer.
`default_nettype none
module adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 400;
  typedef struct packed {
    logic [11:0] cfg;
    logic idle;
    logic busy;
    logic done;
  } row_s;
  // Status pin levels for each mode: idle, converting, after the end.
  row_s rows [5] = '{'{12'hfff, 1'b1, 1'b0, 1'b1},
    '{12'hf7f, 1'b0, 1'b1, 1'b0}, '{12'hfbf, 1'b1, 1'b1, 1'b0},
    '{12'hf3f, 1'b0, 1'b0, 1'b1}, '{12'hbff, 1'b1, 1'b0, 1'b1}};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic go = 1'b0;
  logic sclk_on = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, status_pin;
  logic sclk, conversion_start_n;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  adc_seq_pkg::ana_s ana;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  logic c;

  always #5 clk = ~clk;

  // Free-running cycle count for the wake time measurements.
  int cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;

  adc_conversion_sequencer i_dut (.clk, .srst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sclk,
    .conversion_start_n, .status_pin, .ana);
  host_model i_host (.clk, .go, .sclk_on, .sclk, .conversion_start_n);

  // ----------------------------------------------------------------
  // Checks and closing
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Ends the run when a wait used up its bound.
  task automatic tmo(input int k);
    if (k >= LIM) begin
      num_errors++;
      $display("[ERR] wait expected done seen timeout");
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    int k;
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < LIM && !(aw && w); k++) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    tmo(k);
    for (k = 0; k < LIM && bvalid !== 1'b1; k++) @(posedge clk);
    tmo(k);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int k;
    logic ar;
    ar = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // The address is taken only at an edge that already saw arvalid.
    for (k = 0; k < LIM && !ar; k++) begin
      @(posedge clk);
      ar = (arready === 1'b1);
    end
    tmo(k);
    arvalid <= 1'b0;
    for (k = 0; k < LIM && rvalid !== 1'b1; k++) @(posedge clk);
    tmo(k);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic cfg_wr(input logic [11:0] v);
    wr(adc_seq_pkg::OFS_CFG, {20'h0, v}, r);
  endtask

  task automatic cmd(input logic [3:0] v);
    wr(adc_seq_pkg::OFS_CMD, {16'h0, v, 12'h0}, r);
  endtask

  task automatic strobe();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic wait_hold(input logic v, output int k);
    for (k = 0; k < LIM && ana.hold !== v; k++) @(posedge clk);
    tmo(k);
  endtask

  // Polls the status word until the sequencer is sampling again.
  task automatic wait_idle(output int k);
    int t0;
    int j;
    logic [31:0] s;
    logic [1:0] e;
    t0 = cyc;
    s = 32'h1c0;
    for (j = 0; j < LIM && s[8:6] != adc_seq_pkg::ST_SAMPLE; j++) begin
      rd(adc_seq_pkg::OFS_STAT, s, e);
    end
    k = cyc - t0;
    tmo(j);
  endtask

  task automatic wait_bias(output int k);
    for (k = 0; k < LIM && ana.bias_on !== 1'b1; k++) @(posedge clk);
    tmo(k);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    chk_word("ana_rst", 32'h3, {28'h0, ana});
    chk_bit("pin_rst", 1'b1, status_pin);
    rd(adc_seq_pkg::OFS_CFG, d, r);
    chk_word("cfg_rst", {20'h0, adc_seq_pkg::CFG_RESET}, d);
    rd(4'hc, d, r);
    chk_word("rd_unmapped", 32'h2, {30'h0, r});
    wr(4'hc, 32'h0, r);
    chk_word("wr_unmapped", 32'h2, {30'h0, r});
    foreach (rows[i]) begin
      sclk_on <= ~rows[i].cfg[adc_seq_pkg::B_CLK_SRC];
      cfg_wr(rows[i].cfg);
      rd(adc_seq_pkg::OFS_CFG, d, r);
      chk_word("cfg", {20'h0, rows[i].cfg}, d);
      chk_bit("idle_pin", rows[i].idle, status_pin);
      strobe();
      wait_hold(1'b1, n);
      chk_bit("busy_pin", rows[i].busy, status_pin);
      wait_hold(1'b0, n);
      chk_bit("conv_len", 1'b1, n > 135 && n < 157);
      @(posedge clk);
      chk_bit("done_pin", rows[i].done, status_pin);
      cmd(adc_seq_pkg::CMD_RD_DATA);
      repeat (2) @(posedge clk);
      chk_bit("clear_pin", rows[i].idle, status_pin);
      repeat (40) @(posedge clk);
      $display("test row %0d done", i);
    end
    sclk_on <= 1'b0;
    cfg_wr(12'h7ff);
    cmd(4'h1);
    chk_bit("man_chan", 1'b1, ana.chan);
    cfg_wr(12'hdff);
    wait_hold(1'b1, n);
    chk_bit("first_chan", 1'b0, ana.chan);
    wait_hold(1'b0, n);
    repeat (4) @(posedge clk);
    chk_bit("acq_pin", 1'b0, status_pin);
    wait_hold(1'b1, n);
    chk_bit("acq_len", 1'b1, n > 12 && n < 28);
    chk_bit("next_chan", 1'b1, ana.chan);
    cfg_wr(12'h5ff);
    wait_hold(1'b0, n);
    wait_hold(1'b1, n);
    c = ana.chan;
    wait_hold(1'b0, n);
    wait_hold(1'b1, n);
    chk_bit("chan_stays", c, ana.chan);
    cfg_wr(12'hfff);
    wait_hold(1'b0, n);
    $display("test auto done");
    repeat (40) @(posedge clk);
    strobe();
    wait_hold(1'b1, n);
    cfg_wr(12'hff7);
    repeat (2) @(posedge clk);
    chk_bit("abort", 1'b0, ana.hold);
    chk_bit("nap_bias", 1'b0, ana.bias_on);
    rd(adc_seq_pkg::OFS_CFG, d, r);
    chk_word("cfg_kept", 32'hff7, d);
    cmd(adc_seq_pkg::CMD_WAKE);
    wait_idle(n);
    chk_bit("nap_wake", 1'b1, n < 40);
    rd(adc_seq_pkg::OFS_CFG, d, r);
    chk_word("wake_cfg", 32'hfff, d);
    cfg_wr(12'hffb);
    repeat (2) @(posedge clk);
    chk_bit("deep_osc", 1'b0, ana.osc_on);
    cfg_wr(12'hfff);
    wait_idle(n);
    chk_bit("deep_wake", 1'b1, n > 80 && n < 130);
    $display("test power-down done");
    repeat (40) @(posedge clk);
    cfg_wr(12'hfef);
    strobe();
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
    repeat (2) @(posedge clk);
    chk_bit("anap_bias", 1'b0, ana.bias_on);
    repeat (40) @(posedge clk);
    strobe();
    wait_bias(n);
    chk_bit("strobe_wake", 1'b1, n < 40);
    chk_bit("no_conv", 1'b0, ana.hold);
    repeat (170) @(posedge clk);
    strobe();
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
    repeat (2) @(posedge clk);
    cmd(adc_seq_pkg::CMD_DEFAULT);
    wait_bias(n);
    chk_bit("dflt_wake", 1'b1, n < 40);
    rd(adc_seq_pkg::OFS_CFG, d, r);
    chk_word("dflt_cfg", 32'hfff, d);
    $display("test auto nap done");
    // A reset in mid-run, taken from nap, restores the defaults.
    cfg_wr(12'hff7);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    chk_word("ana_rst2", 32'h3, {28'h0, ana});
    chk_bit("pin_rst2", 1'b1, status_pin);
    rd(adc_seq_pkg::OFS_CFG, d, r);
    chk_word("cfg_rst2", {20'h0, adc_seq_pkg::CFG_RESET}, d);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// ### tb/host_model.sv
// Host side model: start strobe pulses and a gated serial clock.
`default_nettype none
module host_model (
  // Clock.
  input wire logic clk,
  // Requests from the bench.
  input wire logic go,
  input wire logic sclk_on,
  // Converter pins.
  output logic sclk,
  output logic conversion_start_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] low_cnt = 3'h0;
  logic [1:0] div_cnt = 2'h0;
  initial sclk = 1'b0;
  initial conversion_start_n = 1'b1;

  // serial clock at a quarter of clk
  // The serial clock has a 40 ns period and rests low when not in use.
  always @(posedge clk) begin
    div_cnt <= div_cnt + 2'h1;
    if (!sclk_on) begin
      sclk <= 1'b0;
    end else if (div_cnt[0]) begin
      sclk <= ~sclk;
    end
  end

  // strobe low time
  // A request pulls the strobe low for five cycles, then releases it.
  always @(posedge clk) begin
    if (go) begin
      low_cnt <= 3'h5;
      conversion_start_n <= 1'b0;
    end else if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
      conversion_start_n <= (low_cnt == 3'h1);
    end
  end
endmodule
`default_nettype wire
